// *** src/status_ind_pkg.sv ***
// constants and types shared by the status indication logic
package status_ind_pkg;

  // ==========================================
  // lamp patterns
  typedef enum logic [2:0] {
    LAMP_OFF,
    LAMP_SEARCH,
    LAMP_NOT_REG,
    LAMP_TURNING_OFF,
    LAMP_REGISTERED,
    LAMP_CALL
  } lamp_mode_t;

  // ==========================================
  // timing, given in milliseconds and turned into clock cycles
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned FAST_PERIOD_MS = 1000;
  localparam int unsigned FAST_ON_MS = 500;
  localparam int unsigned SLOW_PERIOD_MS = 3000;
  localparam int unsigned SLOW_ON_MS = 300;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned FAST_ON_CYC = FAST_ON_MS * CYC_PER_MS;
  localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned SLOW_ON_CYC = SLOW_ON_MS * CYC_PER_MS;

  // thermal indication interval, a plain choice of 100 ms
  localparam int unsigned THERM_INTERVAL_MS = 100;
  localparam int unsigned THERM_INTERVAL_CYC = THERM_INTERVAL_MS * CYC_PER_MS;

  localparam int unsigned CNT_W = 32;
  localparam int unsigned TEMP_W = 12;

endpackage

// *** src/blink_gen.sv ***
// period and on-time generator for the status lamp
`timescale 1ns/10ps
`default_nettype none
module blink_gen #(
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic restart,
  input wire logic [CNT_W-1:0] period_cyc,
  input wire logic [CNT_W-1:0] on_cyc,
  // result
  output logic lamp_on
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // wrap at period end, restart from start of on-phase
  always_comb begin
    if (restart || (cnt_reg >= period_cyc - {{(CNT_W-1){1'b0}}, 1'b1})) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign lamp_on = (cnt_reg < on_cyc);

endmodule
`default_nettype wire

// *** src/status_indicators.sv ***
// status lamp, boot-complete flag and thermal alarm pin of the module
`timescale 1ns/10ps
`default_nettype none

// Contract
// [RULE_01] output pins are push-pull: driven both high and low, no pull-up needed; the code leaves them undriven until the first clock after reset
// [RULE_02] lamp low while device off, high continuously while a call is active
// [RULE_03] fast blink, 1 s period, 0.5 s on, for search, unregistered, turning off
// [RULE_04] slow blink, 3 s period, 0.3 s on, while registered with full service
// [RULE_05] boot-complete flag stays low until the boot sequence finishes
// [RULE_06] flag goes high once commands are accepted; host waits for it
// [RULE_07] thermal monitor gives periodic temperature indications while enabled
// [RULE_08] when configured, alarm pin rises once maximum temperature is reached; the code raises it only at an indication tick while the monitor is enabled
// [RULE_09] lamp pattern change restarts the blink period at the on-phase; the code restarts only when the blink shape changes, not between fast patterns
module status_indicators #(
  parameter int unsigned FAST_PERIOD = status_ind_pkg::FAST_PERIOD_CYC,
  parameter int unsigned FAST_ON = status_ind_pkg::FAST_ON_CYC,
  parameter int unsigned SLOW_PERIOD = status_ind_pkg::SLOW_PERIOD_CYC,
  parameter int unsigned SLOW_ON = status_ind_pkg::SLOW_ON_CYC,
  parameter int unsigned THERM_INTERVAL = status_ind_pkg::THERM_INTERVAL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // device state from firmware, same clock
  input wire status_ind_pkg::lamp_mode_t lamp_mode,
  input wire logic boot_done,
  // thermal monitor setup, same clock
  input wire logic therm_enable,
  input wire logic therm_alarm_cfg,
  input wire logic [status_ind_pkg::TEMP_W-1:0] therm_limit,
  input wire logic [status_ind_pkg::TEMP_W-1:0] temp_value,
  // pins
  output logic network_status_lamp,
  output logic network_status_lamp_oe,
  output logic boot_complete_flag,
  output logic boot_complete_flag_oe,
  output logic thermal_alarm,
  output logic thermal_alarm_oe,
  // periodic temperature indication
  output logic therm_report_valid,
  output logic [status_ind_pkg::TEMP_W-1:0] therm_report
);

  // counter and temperature widths shared with the package
  localparam int unsigned CW = status_ind_pkg::CNT_W;
  localparam int unsigned TW = status_ind_pkg::TEMP_W;

  // ==========================================
  // lamp pattern selection
  status_ind_pkg::lamp_mode_t mode_reg;
  status_ind_pkg::lamp_mode_t mode_next;
  logic fast_now;
  logic fast_held;
  logic shape_change;
  logic restart;
  logic blink_on;
  logic [CW-1:0] period_sel;
  logic [CW-1:0] on_sel;
  logic lamp_reg;
  logic lamp_next;

  // true for the patterns that share the fast blink
  function automatic logic is_fast(input status_ind_pkg::lamp_mode_t m);
    is_fast = (m == status_ind_pkg::LAMP_SEARCH) || (m == status_ind_pkg::LAMP_NOT_REG) ||
              (m == status_ind_pkg::LAMP_TURNING_OFF);
  endfunction

  // restart only when the blink shape changes, so search to
  // unregistered keeps its rhythm instead of a doubled pulse;
  // period and on-time follow the registered pattern, the same one
  // the lamp level uses, so the edge before a restart still shows
  // the old shape and never a mix of old count and new on-time
  always_comb begin
    mode_next = lamp_mode;
    fast_now = is_fast(lamp_mode);
    fast_held = is_fast(mode_reg);
    shape_change = (lamp_mode != mode_reg) && !(fast_now && fast_held);
    restart = shape_change; // RULE_09
    if (fast_held) begin
      period_sel = CW'(FAST_PERIOD); // RULE_03
      on_sel = CW'(FAST_ON);
    end else begin
      period_sel = CW'(SLOW_PERIOD); // RULE_04
      on_sel = CW'(SLOW_ON);
    end
  end

  // limitation: a restart that lands inside an on-phase carries it
  // straight into the new on-phase, since the count restarts lit
  blink_gen #(
    .CNT_W(CW)
  ) u_blink (
    .clk(clk),
    .arst_n(arst_n),
    .restart(restart),
    .period_cyc(period_sel),
    .on_cyc(on_sel),
    .lamp_on(blink_on)
  );

  // lamp level per pattern
  always_comb begin
    case (mode_reg)
      status_ind_pkg::LAMP_OFF: lamp_next = 1'b0; // RULE_02
      status_ind_pkg::LAMP_CALL: lamp_next = 1'b1; // RULE_02
      status_ind_pkg::LAMP_SEARCH,
      status_ind_pkg::LAMP_NOT_REG,
      status_ind_pkg::LAMP_TURNING_OFF,
      status_ind_pkg::LAMP_REGISTERED: lamp_next = blink_on; // RULE_03 RULE_04
      // spare codes of the 3-bit mode keep the lamp dark
      default: lamp_next = 1'b0;
    endcase
  end

  // pattern and lamp level registered together
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= status_ind_pkg::LAMP_OFF;
      lamp_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      lamp_reg <= lamp_next;
    end
  end

  // ==========================================
  // boot-complete flag
  logic boot_reg;
  logic boot_next;

  // low until boot finishes, then stays high until reset
  // a one-cycle boot_done pulse is enough, the flag holds it
  always_comb begin
    boot_next = boot_reg | boot_done; // RULE_05 RULE_06
  end

  // flag register, cleared only by reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_reg <= 1'b0;
    end else begin
      boot_reg <= boot_next;
    end
  end

  // ==========================================
  // thermal monitor
  logic [CW-1:0] tick_reg;
  logic [CW-1:0] tick_next;
  logic rep_valid_reg;
  logic rep_valid_next;
  logic [TW-1:0] rep_reg;
  logic [TW-1:0] rep_next;
  logic alarm_reg;
  logic alarm_next;
  logic limit_hit;

  // the alarm follows the sampled report, so it only rises on
  // an indication tick; a limit reached between ticks waits at most one interval;
  // the tick restarts from zero on enable, so the first report is a full interval late
  always_comb begin
    limit_hit = (temp_value >= therm_limit); // reached counts as equal
    tick_next = tick_reg;
    rep_valid_next = 1'b0;
    rep_next = rep_reg;
    alarm_next = alarm_reg;
    if (!therm_enable) begin
      tick_next = '0;
      alarm_next = 1'b0;
    end else if (tick_reg >= CW'(THERM_INTERVAL) - {{(CW-1){1'b0}}, 1'b1}) begin
      tick_next = '0;
      rep_valid_next = 1'b1; // RULE_07
      rep_next = temp_value;
      alarm_next = therm_alarm_cfg && limit_hit; // RULE_08
    end else begin
      tick_next = tick_reg + {{(CW-1){1'b0}}, 1'b1};
    end
    if (!therm_alarm_cfg) begin
      alarm_next = 1'b0;
    end
  end

  // tick, report and alarm registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= '0;
      rep_valid_reg <= 1'b0;
      rep_reg <= '0;
      alarm_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      rep_valid_reg <= rep_valid_next;
      rep_reg <= rep_next;
      alarm_reg <= alarm_next;
    end
  end

  // ==========================================
  // pin drive: push-pull, enables always on out of reset
  // the enables stay low during reset, so the board sees floating
  // pins until the first clock edge after release
  logic oe_reg;

  // one shared enable flop for all three pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= 1'b1; // RULE_01
    end
  end

  assign network_status_lamp = lamp_reg;
  assign network_status_lamp_oe = oe_reg;
  assign boot_complete_flag = boot_reg;
  assign boot_complete_flag_oe = oe_reg;
  assign thermal_alarm = alarm_reg;
  assign thermal_alarm_oe = oe_reg;
  assign therm_report_valid = rep_valid_reg;
  assign therm_report = rep_reg;

endmodule
`default_nettype wire

// *** sim/status_indicators_sva.sv ***
// assertions on the status indication pins
`timescale 1ns/10ps
`default_nettype none
module status_indicators_sva #(
  parameter int unsigned FAST_ON = status_ind_pkg::FAST_ON_CYC,
  parameter int unsigned SLOW_ON = status_ind_pkg::SLOW_ON_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // firmware state and thermal setup
  input wire status_ind_pkg::lamp_mode_t lamp_mode,
  input wire logic boot_done,
  input wire logic therm_enable,
  input wire logic therm_alarm_cfg,
  input wire logic [status_ind_pkg::TEMP_W-1:0] therm_limit,
  input wire logic [status_ind_pkg::TEMP_W-1:0] temp_value,
  // pins
  input wire logic network_status_lamp,
  input wire logic network_status_lamp_oe,
  input wire logic boot_complete_flag,
  input wire logic thermal_alarm,
  input wire logic therm_report_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic fast_s, slow_s, chg_reg, chg_next;
  logic [1:0] shp_reg;
  logic [31:0] hi_reg, hi_next;
  // ==========
  // lamp run length; a blink shape change marks the run so only natural falls are judged
  assign fast_s = lamp_mode inside {status_ind_pkg::LAMP_SEARCH, status_ind_pkg::LAMP_NOT_REG,
    status_ind_pkg::LAMP_TURNING_OFF};
  assign slow_s = lamp_mode == status_ind_pkg::LAMP_REGISTERED;
  always_comb begin
    hi_next = network_status_lamp ? hi_reg + 32'h1 : 32'h0;
    chg_next = ({fast_s, slow_s} != shp_reg) | (network_status_lamp & chg_reg);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_reg <= 32'h0;
      chg_reg <= 1'b0;
      shp_reg <= 2'h0;
    end else begin
      hi_reg <= hi_next;
      chg_reg <= chg_next;
      shp_reg <= {fast_s, slow_s};
    end
  end
  AST_LAMP_OE: assert property (1'b1 |=> network_status_lamp_oe)
    else $error("lamp pin not driven");
  AST_OFF_LOW: assert property (lamp_mode == status_ind_pkg::LAMP_OFF |-> ##2 !network_status_lamp)
    else $error("lamp lit while off");
  AST_CALL_HIGH: assert property (lamp_mode == status_ind_pkg::LAMP_CALL |-> ##2 network_status_lamp)
    else $error("lamp dark during call");
  AST_ON_TIME: assert property ($fell(network_status_lamp) && !chg_reg && !chg_next
    && (fast_s || slow_s) |-> hi_reg == (fast_s ? FAST_ON : SLOW_ON)) else $error("wrong lamp on-time");
  AST_FLAG_LOW: assert property (!boot_done && !boot_complete_flag |=> !boot_complete_flag)
    else $error("flag rose before boot");
  AST_FLAG_SET: assert property (boot_done || boot_complete_flag |=> boot_complete_flag)
    else $error("flag not set or lost");
  AST_REPORT_GAP: assert property (therm_report_valid |=> !therm_report_valid [*8])
    else $error("reports too close");
  AST_REPORT_OFF: assert property (!therm_enable |=> !therm_report_valid)
    else $error("report while disabled");
  AST_ALARM_SET: assert property (therm_report_valid |->
    thermal_alarm == $past(therm_alarm_cfg && temp_value >= therm_limit)) else $error("alarm wrong at tick");
  AST_ALARM_DROP: assert property (!therm_alarm_cfg |=> !thermal_alarm)
    else $error("alarm without config");
endmodule
bind status_indicators status_indicators_sva #(.FAST_ON(FAST_ON), .SLOW_ON(SLOW_ON)) i_sva (
  .clk(clk), .arst_n(arst_n), .lamp_mode(lamp_mode), .boot_done(boot_done), .therm_enable(therm_enable),
  .therm_alarm_cfg(therm_alarm_cfg),
  .therm_limit(therm_limit), .temp_value(temp_value), .network_status_lamp(network_status_lamp),
  .network_status_lamp_oe(network_status_lamp_oe), .boot_complete_flag(boot_complete_flag),
  .thermal_alarm(thermal_alarm), .therm_report_valid(therm_report_valid));
`default_nettype wire

// *** sim/host_board_model.sv ***
// host board model: lamp driver input and command gate
`timescale 1ns/10ps
`default_nettype none
module host_board_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins from the module
  input wire logic lamp,
  input wire logic lamp_oe,
  input wire logic flag,
  input wire logic flag_oe,
  // measurements
  output logic [31:0] on_len,
  output logic [31:0] period,
  output logic cmd_ok
);
  logic pin, pin_reg;
  logic [31:0] hi_reg, since_reg;
  // ==========
  // no board pull-up: an undriven pin wanders, so it must never look valid
  assign pin = lamp_oe ? lamp : ~pin_reg;
  assign cmd_ok = flag_oe & flag;
  // on-time and rise-to-rise period of the lamp
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_reg <= 1'b0;
      hi_reg <= 32'h0;
      since_reg <= 32'h0;
      on_len <= 32'h0;
      period <= 32'h0;
    end else begin
      pin_reg <= pin;
      hi_reg <= pin ? hi_reg + 32'h1 : 32'h0;
      since_reg <= (pin & !pin_reg) ? 32'h1 : since_reg + 32'h1;
      if (pin & !pin_reg) period <= since_reg;
      if (!pin & pin_reg) on_len <= hi_reg;
    end
  end
endmodule
`default_nettype wire

// *** sim/status_indicators_tb.sv ***
// testbench for the status indication logic
`timescale 1ns/10ps
`default_nettype none
module status_indicators_tb;
  localparam int unsigned FP = 20, FO = 10, SP = 60, SO = 6, TI = 16;
  logic clk = 0, arst_n = 0, boot_done = 0, therm_enable = 0, therm_alarm_cfg = 0;
  status_ind_pkg::lamp_mode_t lamp_mode = status_ind_pkg::LAMP_OFF;
  logic [status_ind_pkg::TEMP_W-1:0] therm_limit = 12'h100, temp_value = 12'h000, therm_report;
  logic lamp, lamp_oe, flag, flag_oe, alarm, alarm_oe, valid, cmd_ok;
  logic [31:0] on_len, period;
  int n_fail = 0, compares = 0;
  always #5 clk = ~clk;
  status_indicators #(.FAST_PERIOD(FP), .FAST_ON(FO), .SLOW_PERIOD(SP), .SLOW_ON(SO), .THERM_INTERVAL(TI)) i_dut (
    .clk(clk), .arst_n(arst_n), .lamp_mode(lamp_mode), .boot_done(boot_done), .therm_enable(therm_enable),
    .therm_alarm_cfg(therm_alarm_cfg), .therm_limit(therm_limit), .temp_value(temp_value),
    .network_status_lamp(lamp), .network_status_lamp_oe(lamp_oe), .boot_complete_flag(flag),
    .boot_complete_flag_oe(flag_oe), .thermal_alarm(alarm), .thermal_alarm_oe(alarm_oe),
    .therm_report_valid(valid), .therm_report(therm_report));
  host_board_model i_host (.clk(clk), .arst_n(arst_n), .lamp(lamp), .lamp_oe(lamp_oe), .flag(flag),
    .flag_oe(flag_oe), .on_len(on_len), .period(period), .cmd_ok(cmd_ok));
  // ==========
  // shared compare and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("fails=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_boot();
    repeat (4) @(posedge clk);
    #1 chk({flag, cmd_ok, lamp_oe, flag_oe, alarm_oe}, 5'h07);
    @(posedge clk) boot_done <= 1'b1;
    @(posedge clk) boot_done <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({flag, cmd_ok}, 2'h3);
  endtask
  task automatic t_blink(input status_ind_pkg::lamp_mode_t m, input int unsigned per, input int unsigned on);
    @(posedge clk) lamp_mode <= m;
    repeat (3 * per) @(posedge clk);
    #1 chk(on_len, on);
    chk(period, per);
  endtask
  // slow off-phase cut short: the fast pattern must start lit at once
  task automatic t_restart();
    for (int i = 0; i < SP && lamp !== 1'b0; i++) @(negedge clk);
    repeat (10) @(posedge clk);
    lamp_mode <= status_ind_pkg::LAMP_SEARCH;
    repeat (2) @(posedge clk);
    #1 chk(lamp, 1);
    repeat (FO + 1) @(posedge clk);
    #1 chk(on_len, FO);
  endtask
  task automatic t_steady(input status_ind_pkg::lamp_mode_t m, input logic lvl);
    @(posedge clk) lamp_mode <= m;
    repeat (SP) @(posedge clk);
    #1 chk(lamp, lvl);
  endtask
  task automatic t_therm();
    int n;
    logic [11:0] tv [3] = '{12'h0ff, 12'h100, 12'h120};
    @(posedge clk) therm_alarm_cfg <= 1'b1;
    therm_enable <= 1'b1;
    for (n = 0; n < 100 && valid !== 1'b1; n++) @(negedge clk);
    foreach (tv[i]) begin
      @(posedge clk) temp_value <= tv[i];
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (valid !== 1'b1 && n < 100);
      chk(n, TI);
      chk({therm_report, alarm}, {tv[i], tv[i] >= 12'h100});
    end
    @(posedge clk) therm_alarm_cfg <= 1'b0;
    repeat (2) @(negedge clk);
    chk(alarm, 0);
    // disabled monitor: no reports and no alarm even when configured
    @(posedge clk) therm_enable <= 1'b0;
    therm_alarm_cfg <= 1'b1;
    n = 0;
    repeat (2 * TI) begin
      @(negedge clk);
      if (valid !== 1'b0) n++;
    end
    chk(n, 0);
    chk(alarm, 0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_boot();
    t_blink(status_ind_pkg::LAMP_SEARCH, FP, FO);
    t_blink(status_ind_pkg::LAMP_NOT_REG, FP, FO);
    t_blink(status_ind_pkg::LAMP_TURNING_OFF, FP, FO);
    t_blink(status_ind_pkg::LAMP_REGISTERED, SP, SO);
    t_restart();
    t_steady(status_ind_pkg::LAMP_CALL, 1'b1);
    t_steady(status_ind_pkg::LAMP_OFF, 1'b0);
    t_therm();
    print_verdict();
  end
  // watchdog, about three times the expected run
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
